// [ddr_fast_cycle_dram_commands_tb.sv]
// Self-checking bench joining the controller end and the memory end.
module ddr_fast_cycle_dram_commands_tb
    import fcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              ref_clk_i   = 1'b0;
    logic              srst_i      = 1'b1;
    logic              cmd_valid   = 1'b0;
    op_t               cmd_op      = OP_READ;
    logic [1:0]        cmd_bank    = 2'h0;
    logic [ADDR_W-1:0] cmd_upper   = 15'h0000;
    logic [LA_W-1:0]   cmd_lower   = 7'h00;
    logic [63:0]       cmd_wdata   = 64'h0;
    logic [63:0]       rdata;
    logic [63:0]       p;
    logic              cmd_ready;
    logic              rdata_valid;
    logic              refresh_due;
    logic [2:0]        status;
    int                err_count   = 0;
    int                comparisons = 0;
    op_t               lp_op [3]   = '{OP_REFRESH, OP_POWER_DOWN, OP_SELF_REF};
    always #12.5 ref_clk_i = ~ref_clk_i;
    fcd_link_if fcd_link_if_i ();
    fcd_controller fcd_controller_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .link(fcd_link_if_i),
        .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_bank_i(cmd_bank), .cmd_upper_i(cmd_upper),
        .cmd_lower_i(cmd_lower), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(cmd_ready), .rdata_o(rdata),
        .rdata_valid_o(rdata_valid), .refresh_due_o(refresh_due));
    fcd_device fcd_device_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .link(fcd_link_if_i),
        .self_refresh_o(status[2]), .power_down_o(status[1]), .refreshing_o(status[0]));
    fcd_link_chk fcd_link_chk_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ck(fcd_link_if_i.ck),
        .cs_n(fcd_link_if_i.cs_n), .power_down_n(fcd_link_if_i.power_down_n),
        .h_dq_oe(fcd_link_if_i.h_dq_oe), .h_stb_oe(fcd_link_if_i.h_stb_oe),
        .d_dq_oe(fcd_link_if_i.d_dq_oe), .d_stb_oe(fcd_link_if_i.d_stb_oe),
        .lower_byte_strobe(fcd_link_if_i.lower_byte_strobe),
        .upper_byte_strobe(fcd_link_if_i.upper_byte_strobe));
    ////////////////////////////////////////////////////////////
    function automatic logic [63:0] pat(input int b);
        return 64'h0123_4567_89AB_CDEF + 64'(b) * 64'h1111_1111_1111_1111;
    endfunction
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Requests are held until ready is seen, since the controller takes one only every other cycle.
    task automatic issue(input op_t op, input logic [1:0] b, input logic [14:0] u, input logic [6:0] l,
                         input logic [63:0] w);
        int n = 0;
        @(negedge ref_clk_i);
        {cmd_op, cmd_bank, cmd_upper, cmd_lower, cmd_wdata, cmd_valid} = {op, b, u, l, w, 1'b1};
        while (cmd_ready !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        @(negedge ref_clk_i);
        cmd_valid = 1'b0;
        chk("request taken", 64'h1, 64'(n < 4000));
    endtask
    task automatic rd(input logic [1:0] b, input logic [14:0] u, input logic [6:0] l,
                      input logic [63:0] exp, input logic [63:0] msk);
        int n = 0;
        issue(OP_READ, b, u, l, 64'h0);
        while (rdata_valid !== 1'b1 && n < 400) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("read data", exp, rdata & msk);
    endtask
    task automatic await_st(input logic [2:0] exp);
        int n = 0;
        while (status !== exp && n < 2000) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("status", 64'(exp), 64'(status));
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        err_count++;
        final_report();
    end
    initial begin
        repeat (12) @(negedge ref_clk_i);
        srst_i = 1'b0;
        // The memory end leaves reset only a few link clocks after this.
        repeat (12) @(negedge ref_clk_i);
        issue(OP_MODE, 2'h0, 15'h0032, 7'h00, 64'h0);
        for (int b = 0; b < 4; b++) issue(OP_WRITE, 2'(b), 15'(b), 7'h04, pat(b));
        for (int b = 3; b >= 0; b--) rd(2'(b), 15'(b), 7'h04, pat(b), '1);
        $display("test four banks done");
        issue(OP_MODE, 2'h0, 15'h003A, 7'h00, 64'h0);
        p = pat(1);
        rd(2'h1, 15'h0001, 7'h05, {p[47:32], p[63:48], p[15:0], p[31:16]}, '1);
        $display("test interleave done");
        issue(OP_MODE, 2'h0, 15'h0041, 7'h00, 64'h0);
        issue(OP_WRITE, 2'h3, 15'h0002, 7'h11, 64'h5A5A_A5A5);
        rd(2'h3, 15'h0002, 7'h11, 64'h5A5A_A5A5, 64'hFFFF_FFFF);
        $display("test short burst done");
        foreach (lp_op[k]) begin
            issue(lp_op[k], 2'h0, 15'h0000, 7'h00, 64'h0);
            await_st(3'h1 << k);
            if (k > 0) issue(OP_WAKE, 2'h0, 15'h0000, 7'h00, 64'h0);
            await_st(3'h0);
            rd(2'h3, 15'h0002, 7'h11, 64'h5A5A_A5A5, 64'hFFFF_FFFF);
        end
        issue(OP_POWER_DOWN, 2'h0, 15'h0000, 7'h00, 64'h0);
        await_st(3'h2);
        await_st(3'h0);
        chk("refresh due", 64'h1, 64'(refresh_due));
        $display("test low power done");
        final_report();
    end
endmodule

// [fcd_controller.sv]
// Controller end: makes the link clock and issues command pairs, data and refresh.
// Notes on behaviour
// - Second command follows first by one clock.
// - Write strobe toggles for the whole burst.
// - Power-down waits until read burst finishes.
// - Power-down waits write latency plus two.
// - Leave power-down within average refresh interval.
// - Fifteen clocks after auto-refresh before next.
// - Average refresh interval over eight stays bounded.
// - Late power-down turns self-refresh into refresh.
// - Clock runs sixteen cycles after self-refresh entry.
// - Only deselects during refresh period after exit.
// - Reads wait for lock time after exit.
// - One auto-refresh straight after self-refresh exit.
// - Inputs sampled on rising true clock.
// - Never power down during read or write.
// - Operation decoded from two consecutive commands.
// - Bank bits latched with the first command.
// - Upper address first, lower address second.
// - Data on both strobe edges, per byte.
// - Read data CAS latency after lower address.
// - Write data CAS latency minus one after.
// - Refresh after write-activate cancels the write.
// - Refresh every 7.8 us, at most eight per 3.2 us; the code only raises refresh_due_o after 7.8 us and refreshes on request.
module fcd_controller
    import fcd_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    fcd_link_if.host               link,
    input  wire logic              cmd_valid_i,
    input  wire op_t               cmd_op_i,
    input  wire logic [1:0]        cmd_bank_i,
    input  wire logic [ADDR_W-1:0] cmd_upper_i,
    input  wire logic [LA_W-1:0]   cmd_lower_i,
    input  wire logic [63:0]       cmd_wdata_i,
    output logic                   cmd_ready_o,
    output logic [63:0]            rdata_o,
    output logic                   rdata_valid_o,
    output logic                   refresh_due_o
);
    typedef enum logic [2:0] {
        H_IDLE   = 3'h0,
        H_SECOND = 3'h1,
        H_WAIT   = 3'h2,
        H_SR_ENT = 3'h3,
        H_SR     = 3'h4,
        H_PD     = 3'h5
    } host_state_t;

    host_state_t     state;
    op_t             op;
    logic [2:0]      cl;
    logic [2:0]      bl;
    logic [1:0]      sec_bank;
    logic [ADDR_W-1:0] sec_addr;
    logic [63:0]     wbuf;
    logic [7:0]      wait_cnt;
    logic [7:0]      lock_cnt;
    logic [7:0]      gap_cnt;
    logic [7:0]      age_cnt;
    logic [7:0]      pd_cnt;
    logic            ref_pend;
    logic [2:0]      wd_cnt;
    logic [2:0]      wb_left;
    logic [1:0]      rcnt;
    logic            lstb_last;

    wire             tick = link.ck;
    wire             take = cmd_valid_i && cmd_ready_o;
    wire             wr_go = wd_cnt == 3'h1 || wb_left != 3'h0;
    wire             rd_edge = link.lower_byte_strobe != lstb_last;
    wire             idle_ok = !ref_pend && gap_cnt == 8'h00 && lock_cnt == 8'h00;
    wire             can_take = (state == H_IDLE && idle_ok) || state == H_SR || state == H_PD;
    wire [7:0]       burst_wait = 8'(cl) + 8'(bl) + 8'(BURST_PAD_CYCLES);
    wire             wake = (take && cmd_op_i == OP_WAKE) || pd_cnt == 8'(REFI_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // The link clock is half the reference clock; link outputs move as it falls.
    always_ff @(posedge ref_clk_i) begin
        // The divider runs through reset so that the memory end can clock its own reset in.
        if (link.ck) begin
            link.ck <= 1'b0;
        end else begin
            link.ck <= 1'b1;
        end
        if (srst_i) begin
            cmd_ready_o <= 1'b0;
            rdata_valid_o <= 1'b0;
            refresh_due_o <= 1'b0;
        end else begin
            cmd_ready_o <= !link.ck && can_take;
            rdata_valid_o <= tick && rd_edge && rcnt == 2'(bl - 3'h1);
            refresh_due_o <= age_cnt >= 8'(REFI_CYCLES);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencing, one step per link clock.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state <= H_IDLE;
            op <= OP_READ;
            cl <= CL3_CLOCKS;
            bl <= BL4_WORDS;
            sec_bank <= 2'h0;
            sec_addr <= '0;
            wbuf <= '0;
            wait_cnt <= 8'h00;
            lock_cnt <= 8'h00;
            gap_cnt <= 8'h00;
            age_cnt <= 8'h00;
            pd_cnt <= 8'h00;
            ref_pend <= 1'b0;
            link.cs_n <= ~CS_ACTIVE;
            link.function_control <= FN_LAL;
            link.bank <= 2'h0;
            link.addr <= '0;
            link.power_down_n <= 1'b1;
        end else if (tick) begin
            link.cs_n <= ~CS_ACTIVE;
            link.function_control <= FN_LAL;
            gap_cnt <= (gap_cnt != 8'h00) ? gap_cnt - 8'h01 : gap_cnt;
            lock_cnt <= (lock_cnt != 8'h00) ? lock_cnt - 8'h01 : lock_cnt;
            age_cnt <= (age_cnt != 8'hFF) ? age_cnt + 8'h01 : age_cnt;
            case (state)
                H_IDLE: begin
                    if (ref_pend) begin
                        ref_pend <= 1'b0;
                        op <= OP_REFRESH;
                        link.cs_n <= CS_ACTIVE;
                        link.function_control <= FN_WRITE;
                        state <= H_SECOND;
                    end else if (take) begin
                        op <= cmd_op_i;
                        sec_bank <= cmd_bank_i;
                        sec_addr <= (cmd_op_i == OP_MODE) ? cmd_upper_i : ADDR_W'(cmd_lower_i);
                        wbuf <= cmd_wdata_i;
                        link.bank <= cmd_bank_i;
                        link.addr <= cmd_upper_i;
                        if (cmd_op_i == OP_POWER_DOWN) begin
                            link.power_down_n <= 1'b0;
                            pd_cnt <= 8'h00;
                            state <= H_PD;
                        end else if (cmd_op_i != OP_WAKE) begin
                            link.cs_n <= CS_ACTIVE;
                            link.function_control <=
                                (cmd_op_i == OP_READ || cmd_op_i == OP_MODE) ? FN_READ : FN_WRITE;
                            state <= H_SECOND;
                        end
                    end
                end
                H_SECOND: begin
                    link.cs_n <= CS_ACTIVE;
                    link.bank <= sec_bank;
                    link.addr <= sec_addr;
                    link.function_control <= (op == OP_READ || op == OP_WRITE) ? FN_LAL : FN_REF;
                    state <= H_WAIT;
                    wait_cnt <= burst_wait;
                    if (op == OP_MODE) begin
                        wait_cnt <= 8'(MODE_SET_CYCLES);
                        if (sec_bank == BANK_REGULAR) begin
                            bl <= mode_bl(sec_addr[BL_LSB +: 3]);
                            cl <= mode_cl(sec_addr[CL_LSB +: 3]);
                        end
                    end else if (op == OP_REFRESH || op == OP_SELF_REF) begin
                        wait_cnt <= 8'(REFC_CYCLES);
                        gap_cnt <= 8'(REF_MIN_CYCLES);
                        age_cnt <= 8'h00;
                        state <= (op == OP_SELF_REF) ? H_SR_ENT : H_WAIT;
                    end
                end
                H_SR_ENT: begin
                    link.power_down_n <= 1'b0;
                    state <= H_SR;
                end
                H_SR: begin
                    age_cnt <= 8'h00;
                    if (take && cmd_op_i == OP_WAKE) begin
                        link.power_down_n <= 1'b1;
                        wait_cnt <= 8'(REFC_CYCLES);
                        lock_cnt <= 8'(DLL_LOCK_CYCLES);
                        ref_pend <= 1'b1;
                        state <= H_WAIT;
                    end
                end
                H_PD: begin
                    pd_cnt <= pd_cnt + 8'h01;
                    if (wake) begin
                        link.power_down_n <= 1'b1;
                        wait_cnt <= 8'(ENTRY_VALID_LIMIT + 1);
                        state <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    wait_cnt <= wait_cnt - 8'h01;
                    if (wait_cnt <= 8'h01) begin
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write data starts CL-1 clocks after the lower address; read words are gathered by index.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wd_cnt <= 3'h0;
            wb_left <= 3'h0;
            rcnt <= 2'h0;
            lstb_last <= 1'b0;
            rdata_o <= '0;
            link.h_dq <= '0;
            link.h_dq_oe <= 1'b0;
            link.h_lstb <= 1'b0;
            link.h_ustb <= 1'b0;
            link.h_stb_oe <= 1'b0;
        end else if (tick) begin
            lstb_last <= link.lower_byte_strobe;
            if (state == H_SECOND && op == OP_WRITE) begin
                wd_cnt <= cl - 3'h1;
            end else if (wd_cnt != 3'h0) begin
                wd_cnt <= wd_cnt - 3'h1;
            end
            link.h_dq_oe <= wr_go;
            link.h_stb_oe <= wr_go;
            if (wr_go) begin
                link.h_dq <= wbuf[{wb_left == 3'h0 ? 2'h0 : 2'(bl - wb_left), 4'h0} +: DQ_W];
                link.h_lstb <= ~link.h_lstb;
                link.h_ustb <= ~link.h_ustb;
                wb_left <= (wd_cnt == 3'h1) ? bl - 3'h1 : wb_left - 3'h1;
            end else begin
                link.h_lstb <= 1'b0;
                link.h_ustb <= 1'b0;
            end
            if (state == H_SECOND) begin
                rcnt <= 2'h0;
            end else if (rd_edge && !link.h_stb_oe) begin
                rdata_o[{rcnt, 4'h0} +: DQ_W] <= link.dq;
                rcnt <= rcnt + 2'h1;
            end
        end
    end
endmodule

// [fcd_device.sv]
// Memory end: two-command decoder, mode register, burst data path and refresh states.
module fcd_device
    import fcd_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    fcd_link_if.dev   link,
    output logic      self_refresh_o,
    output logic      power_down_o,
    output logic      refreshing_o
);
    typedef enum logic [2:0] {
        D_IDLE     = 3'h0,
        D_RD_ACT   = 3'h1,
        D_WR_ACT   = 3'h2,
        D_REFRESH  = 3'h3,
        D_SELF_REF = 3'h4,
        D_PWR_DOWN = 3'h5
    } dev_state_t;

    dev_state_t      state;
    logic [2:0]      rst_s;
    logic            rst_l;
    logic [2:0]      pd_s;
    logic            pd_n;
    logic [1:0]      ba;
    logic [1:0]      ua;
    logic [LA_W-1:0] la;
    logic [2:0]      cl;
    logic [2:0]      bl;
    logic            inter;
    logic [2:0]      rd_cnt;
    logic [2:0]      rd_left;
    logic [1:0]      rd_idx;
    logic            wr_on;
    logic [1:0]      wr_idx;
    logic            lstb_q;
    logic            ustb_q;
    logic [4:0]      ref_cnt;
    logic [2:0]      st_lnk;
    logic [2:0]      st_s1;
    logic [2:0]      st_s2;
    logic [2:0]      st_s3;
    logic [DQ_W-1:0] mem [0:(1<<MEM_AW)-1];

    wire             sel = link.cs_n == CS_ACTIVE;
    wire             lower_address_latch_cmd = sel && link.function_control == FN_LAL;
    wire             ref2 = sel && link.function_control == FN_REF;
    wire             bl4 = bl == BL4_WORDS;
    wire             rd_go = rd_cnt == 3'h1 || rd_left != 3'h0;
    wire [MEM_AW-1:0] rd_a = {ba, ua, burst_la(la, rd_idx, bl4, inter)};
    wire [MEM_AW-1:0] wr_a = {ba, ua, burst_la(la, wr_idx, bl4, inter)};
    wire             l_edge = link.lower_byte_strobe != lstb_q;
    wire             u_edge = link.upper_byte_strobe != ustb_q;
    wire             sr_ok = !pd_n && ref_cnt <= 5'(ENTRY_VALID_LIMIT);
    wire [2:0]       st_agree = st_s2 ~^ st_s3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset and power-down input are caught on the link clock with agreeing stages.
    always_ff @(posedge link.ck) begin
        rst_s <= {rst_s[1:0], srst_i};
        pd_s <= {pd_s[1:0], link.power_down_n};
        if (rst_s[1] == rst_s[2]) begin
            rst_l <= rst_s[2];
        end
        if (pd_s[1] == pd_s[2]) begin
            pd_n <= pd_s[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decoding, all inputs taken on the rising link clock.
    always_ff @(posedge link.ck) begin
        if (rst_l) begin
            state <= D_IDLE;
            ba <= 2'h0;
            ua <= 2'h0;
            la <= '0;
            cl <= CL3_CLOCKS;
            bl <= BL4_WORDS;
            inter <= 1'b0;
            wr_on <= 1'b0;
            wr_idx <= 2'h0;
            ref_cnt <= 5'h00;
            st_lnk <= 3'h0;
        end else begin
            ref_cnt <= ref_cnt + 5'h01;
            st_lnk <= {state == D_REFRESH, state == D_PWR_DOWN, state == D_SELF_REF};
            if (wr_on && l_edge) begin
                wr_idx <= wr_idx + 2'h1;
                wr_on <= ({1'b0, wr_idx} + 3'h1) != bl;
            end
            case (state)
                D_IDLE: begin
                    if (!pd_n) begin
                        state <= D_PWR_DOWN;
                    end else if (sel) begin
                        ba <= link.bank;
                        ua <= link.addr[1:0];
                        state <= (link.function_control == FN_READ) ? D_RD_ACT : D_WR_ACT;
                    end
                end
                D_RD_ACT: begin
                    state <= D_IDLE;
                    if (lower_address_latch_cmd) begin
                        la <= link.addr[LA_W-1:0];
                    end else if (ref2 && link.bank == BANK_REGULAR) begin
                        bl <= mode_bl(link.addr[BL_LSB +: 3]);
                        inter <= link.addr[BT_BIT];
                        cl <= mode_cl(link.addr[CL_LSB +: 3]);
                    end
                end
                D_WR_ACT: begin
                    state <= D_IDLE;
                    if (lower_address_latch_cmd) begin
                        la <= link.addr[LA_W-1:0];
                        wr_on <= 1'b1;
                        wr_idx <= 2'h0;
                    end else if (ref2) begin
                        state <= D_REFRESH;
                        ref_cnt <= 5'h00;
                    end
                end
                D_REFRESH: begin
                    if (sr_ok) begin
                        state <= D_SELF_REF;
                    end else if (ref_cnt == 5'(REFC_CYCLES - 1)) begin
                        state <= pd_n ? D_IDLE : D_PWR_DOWN;
                    end
                end
                D_SELF_REF: begin
                    if (pd_n) begin
                        state <= D_REFRESH;
                        ref_cnt <= 5'(ENTRY_VALID_LIMIT + 1);
                    end
                end
                D_PWR_DOWN: begin
                    if (pd_n) begin
                        state <= D_IDLE;
                    end
                end
                default: state <= D_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read burst: first word CL clocks after the lower address, one word per strobe edge.
    always_ff @(posedge link.ck) begin
        lstb_q <= link.lower_byte_strobe;
        ustb_q <= link.upper_byte_strobe;
        if (rst_l) begin
            rd_cnt <= 3'h0;
            rd_left <= 3'h0;
            rd_idx <= 2'h0;
            link.d_dq <= '0;
            link.d_dq_oe <= 1'b0;
            link.d_lstb <= 1'b0;
            link.d_ustb <= 1'b0;
            link.d_stb_oe <= 1'b0;
        end else begin
            if (state == D_RD_ACT && lower_address_latch_cmd) begin
                rd_cnt <= cl;
            end else if (rd_cnt != 3'h0) begin
                rd_cnt <= rd_cnt - 3'h1;
            end
            link.d_dq_oe <= rd_go;
            link.d_stb_oe <= rd_go;
            if (rd_go) begin
                link.d_dq <= mem[rd_a];
                link.d_lstb <= ~link.d_lstb;
                link.d_ustb <= ~link.d_ustb;
                rd_idx <= rd_idx + 2'h1;
                rd_left <= (rd_cnt == 3'h1) ? bl - 3'h1 : rd_left - 3'h1;
            end else begin
                rd_idx <= 2'h0;
                link.d_lstb <= 1'b0;
                link.d_ustb <= 1'b0;
            end
        end
    end

    // Each byte lane is latched on its own strobe edge, at the word index that only the lower strobe edges step.
    always_ff @(posedge link.ck) begin
        if (wr_on && l_edge) begin
            mem[wr_a][7:0] <= link.dq[7:0];
        end
        if (wr_on && u_edge) begin
            mem[wr_a][15:8] <= link.dq[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status crosses to the reference clock; a bit changes once two stages agree.
    always_ff @(posedge ref_clk_i) begin
        st_s1 <= st_lnk;
        st_s2 <= st_s1;
        st_s3 <= st_s2;
        if (srst_i) begin
            self_refresh_o <= 1'b0;
            power_down_o <= 1'b0;
            refreshing_o <= 1'b0;
        end else begin
            self_refresh_o <= st_agree[0] ? st_s3[0] : self_refresh_o;
            power_down_o <= st_agree[1] ? st_s3[1] : power_down_o;
            refreshing_o <= st_agree[2] ? st_s3[2] : refreshing_o;
        end
    end
endmodule

// [fcd_link_chk.sv]
// Concurrent checks on the link that joins the controller end and the memory end.
module fcd_link_chk (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic power_down_n,
    input wire logic h_dq_oe,
    input wire logic h_stb_oe,
    input wire logic d_dq_oe,
    input wire logic d_stb_oe,
    input wire logic lower_byte_strobe,
    input wire logic upper_byte_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////
    a_data_no_fight: assert property (!(h_dq_oe && d_dq_oe)) else $error("both ends drive data");
    a_strobe_no_fight: assert property (!(h_stb_oe && d_stb_oe)) else $error("both ends drive strobes");
    a_strobes_paired: assert property (lower_byte_strobe == upper_byte_strobe) else $error("strobes differ");
    // A stalled link clock would cut self-refresh entry short of its sixteen edges.
    a_clock_runs: assert property (!$past(srst_i) |-> ck != $past(ck)) else $error("link clock stalled");
    a_reset_quiet: assert property (disable iff (1'b0) srst_i |=> cs_n && power_down_n && !h_dq_oe)
        else $error("busy");
    a_pd_mid_op: assert property ($fell(power_down_n) |-> !h_stb_oe && !d_stb_oe) else $error("pd mid transfer");
    a_pd_host_quiet: assert property (!power_down_n |-> !h_dq_oe && !h_stb_oe) else $error("host drives in pd");
    a_pd_dev_quiet: assert property (!power_down_n |-> !d_dq_oe && !d_stb_oe) else $error("memory drives in pd");
    a_exit_deselect: assert property ($rose(power_down_n) |-> cs_n [*8]) else $error("command after wake");
endmodule

// [fcd_link_if.sv]
// Link between the controller end and the memory end, with two-way pins resolved here.
interface fcd_link_if;
    import fcd_pkg::*;
    logic            ck;
    logic            cs_n;
    logic            function_control;
    logic [1:0]      bank;
    logic [ADDR_W-1:0] addr;
    logic            power_down_n;
    logic [DQ_W-1:0] h_dq;
    logic            h_dq_oe;
    logic            h_lstb;
    logic            h_ustb;
    logic            h_stb_oe;
    logic [DQ_W-1:0] d_dq;
    logic            d_dq_oe;
    logic            d_lstb;
    logic            d_ustb;
    logic            d_stb_oe;
    logic [DQ_W-1:0] dq;
    logic            lower_byte_strobe;
    logic            upper_byte_strobe;

    assign dq = d_dq_oe ? d_dq : (h_dq_oe ? h_dq : '0);
    assign lower_byte_strobe = d_stb_oe ? d_lstb : (h_stb_oe ? h_lstb : 1'b0);
    assign upper_byte_strobe = d_stb_oe ? d_ustb : (h_stb_oe ? h_ustb : 1'b0);

    modport host (output ck, cs_n, function_control, bank, addr, power_down_n,
                  output h_dq, h_dq_oe, h_lstb, h_ustb, h_stb_oe,
                  input dq, lower_byte_strobe, upper_byte_strobe);
    modport dev (input ck, cs_n, function_control, bank, addr, power_down_n,
                 output d_dq, d_dq_oe, d_lstb, d_ustb, d_stb_oe,
                 input dq, lower_byte_strobe, upper_byte_strobe);
endinterface

// [fcd_pkg.sv]
// Shared constants, encodings and helpers for both ends of the fast-cycle DRAM link.
package fcd_pkg;
    localparam int REF_CLK_NS = 25;
    localparam int CK_NS = 2 * REF_CLK_NS;
    localparam int REFC_CYCLES = 15;
    localparam int REFI_NS = 7800;
    localparam int REFI_CYCLES = REFI_NS / CK_NS;
    localparam int REF_MIN_NS = 400;
    localparam int REF_MIN_CYCLES = (REF_MIN_NS + CK_NS - 1) / CK_NS;
    localparam int SR_CLOCK_CYCLES = 16;
    localparam int ENTRY_VALID_LIMIT = 4;
    localparam int DLL_LOCK_CYCLES = 200;
    localparam int MODE_SET_CYCLES = 2;
    localparam int BURST_PAD_CYCLES = 2;

    localparam int DQ_W = 16;
    localparam int ADDR_W = 15;
    localparam int LA_W = 7;
    localparam int MEM_AW = 11;

    localparam logic CS_ACTIVE = 1'b0;
    localparam logic FN_READ = 1'b1;
    localparam logic FN_WRITE = 1'b0;
    localparam logic FN_LAL = 1'b1;
    localparam logic FN_REF = 1'b0;

    localparam logic [1:0] BANK_REGULAR = 2'h0;
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam logic [2:0] BL2_CODE = 3'h1;
    localparam logic [2:0] CL4_CODE = 3'h4;
    localparam logic [2:0] BL2_WORDS = 3'h2;
    localparam logic [2:0] BL4_WORDS = 3'h4;
    localparam logic [2:0] CL3_CLOCKS = 3'h3;
    localparam logic [2:0] CL4_CLOCKS = 3'h4;

    typedef enum logic [2:0] {
        OP_READ       = 3'h0,
        OP_WRITE      = 3'h1,
        OP_REFRESH    = 3'h2,
        OP_MODE       = 3'h3,
        OP_SELF_REF   = 3'h4,
        OP_POWER_DOWN = 3'h5,
        OP_WAKE       = 3'h6
    } op_t;

    // Reserved burst length codes fall back to four words.
    function automatic logic [2:0] mode_bl(input logic [2:0] code);
        return (code == BL2_CODE) ? BL2_WORDS : BL4_WORDS;
    endfunction

    // Reserved latency codes fall back to three clocks.
    function automatic logic [2:0] mode_cl(input logic [2:0] code);
        return (code == CL4_CODE) ? CL4_CLOCKS : CL3_CLOCKS;
    endfunction

    function automatic logic [LA_W-1:0] burst_la(input logic [LA_W-1:0] la, input logic [1:0] idx,
                                                 input logic bl4, input logic inter);
        logic [1:0] lo;
        lo = inter ? (la[1:0] ^ idx) : (la[1:0] + idx);
        return bl4 ? {la[LA_W-1:2], lo} : {la[LA_W-1:1], lo[0]};
    endfunction
endpackage
